/* File: design/report_pkg.sv */
// constants and types for the pointer report formatter
package report_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD = 4800;
    localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD);
    localparam logic [7:0] CMD_PROMPT = 8'h44;
    localparam logic [7:0] CMD_STREAM = 8'h52;
    localparam logic [7:0] CMD_POSITION = 8'h50;
    localparam logic [7:0] CMD_SELFTEST = 8'h54;
    localparam logic [2:0] SYNC_PATTERN = 3'h5;
    localparam logic [6:0] ERR_NONE = 7'h00;
    localparam logic [6:0] ERR_CHECKSUM = 7'h3E;
    localparam logic [6:0] ERR_BUTTON = 7'h3D;
    localparam logic [1:0] POS_LEN = 2'h3;
    localparam logic [1:0] TEST_LEN = 2'h0;
    localparam int TX_BITS = 11;
    typedef enum logic [2:0] {
        IDLE = 3'b001,
        SEND = 3'b010,
        WAIT = 3'b100
    } fmt_state_t;
    function automatic logic [6:0] magnitude(input logic signed [15:0] v);
        logic [15:0] a;
        a = v[15] ? 16'(-v) : 16'(v);
        return a[6:0];
    endfunction : magnitude
endpackage : report_pkg

/* File: design/byte_link_if.sv */
// byte handshake between formatter and serial transmitter
interface byte_link_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_link_if

/* File: design/serial_tx.sv */
// asynchronous serial transmitter, 8 data bits, odd parity, one stop bit
module serial_tx #(
    parameter logic [15:0] BIT_CYCLES = report_pkg::BIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    byte_link_if.snk link,
    output logic txd
);
    logic [10:0] shift;
    logic [10:0] next_shift;
    logic [3:0] bitsLeft;
    logic [3:0] next_bitsLeft;
    logic [15:0] baudCnt;
    logic [15:0] next_baudCnt;

    assign link.ready = (bitsLeft == 4'h0);

    always_comb begin
        next_shift = shift;
        next_bitsLeft = bitsLeft;
        next_baudCnt = baudCnt;
        if (bitsLeft == 4'h0) begin
            if (link.valid) begin
                // stop, odd parity, data lsb first, start
                next_shift = {1'b1, ~^link.data, link.data, 1'b0};
                next_bitsLeft = 4'(report_pkg::TX_BITS);
                next_baudCnt = BIT_CYCLES - 16'h0001;
            end
        end else if (baudCnt == 16'h0000) begin
            next_shift = {1'b1, shift[10:1]};
            next_bitsLeft = bitsLeft - 4'h1;
            next_baudCnt = BIT_CYCLES - 16'h0001;
        end else begin
            next_baudCnt = baudCnt - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shift <= 11'h7FF;
            bitsLeft <= 4'h0;
            baudCnt <= 16'h0000;
        end else begin
            shift <= next_shift;
            bitsLeft <= next_bitsLeft;
            baudCnt <= next_baudCnt;
        end
    end

    // ones shift in behind the frame, so the line rests high from a flip-flop
    assign txd = shift[0];

    parity_odd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        link.valid && link.ready |=> ^shift[9:1])
        else $error("parity not odd");
endmodule : serial_tx

/* File: design/pointer_report_formatter.sv */
// pointer report formatter: builds position and self-test reports
// Behaviour
// - byte two: zero, then X magnitude
// - byte three: zero, then Y magnitude
// - overflow gives no indication anywhere
// - self-test byte one starts with 101
// - self-test byte one low bits: revision
// - self-test byte three: zero, error code
// - self-test byte four: zeros, switch faults
// - position byte one: one, zeros, signs, buttons
// - 4800 baud, odd parity, one stop
// - self-test report is four bytes
// - position request: report, then prompt mode
module pointer_report_formatter #(
    parameter logic [4:0] REVISION = 5'h01,
    parameter logic [2:0] MAKER_ID = 3'h1,   // arbitrary value
    parameter logic [3:0] DEVICE_ID = 4'h1,  // arbitrary value
    parameter logic [15:0] BIT_CYCLES = report_pkg::BIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    input wire logic moveStrobe,
    input wire logic signed [1:0] deltaX,
    input wire logic signed [1:0] deltaY,
    input wire logic [2:0] buttons,
    input wire logic [6:0] testError,
    input wire logic [2:0] switchFault,
    output logic txd,
    output logic streamMode,
    output logic reportBusy
);
    // ------------------------------------------------------------
    // accumulation and mode
    // ------------------------------------------------------------
    logic signed [15:0] accX;
    logic signed [15:0] accY;
    logic signed [15:0] next_accX;
    logic signed [15:0] next_accY;
    logic next_streamMode;
    logic [2:0] lastButtons;
    logic [2:0] next_lastButtons;
    report_pkg::fmt_state_t state;
    report_pkg::fmt_state_t next_state;
    logic [7:0] bytes [4];
    logic [7:0] next_bytes [4];
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic [1:0] lastIdx;
    logic [1:0] next_lastIdx;
    logic loadPos;
    logic loadTest;
    byte_link_if link ();
    logic [2:0] btnMeta;
    logic [2:0] btnSync;
    logic [2:0] btnLate;
    logic [2:0] btnStable;
    logic [2:0] next_btnMeta;
    logic [2:0] next_btnSync;
    logic [2:0] next_btnLate;
    logic [2:0] next_btnStable;

    serial_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .link(link),
        .txd(txd)
    );

    // ------------------------------------------------------------
    // button synchroniser
    // ------------------------------------------------------------
    always_comb begin
        next_btnMeta = buttons;
        next_btnSync = btnMeta;
        next_btnLate = btnSync;
        // a change counts once both late stages agree
        next_btnStable = (btnSync == btnLate) ? btnLate : btnStable;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            btnMeta <= 3'h0;
            btnSync <= 3'h0;
            btnLate <= 3'h0;
            btnStable <= 3'h0;
        end else begin
            btnMeta <= next_btnMeta;
            btnSync <= next_btnSync;
            btnLate <= next_btnLate;
            btnStable <= next_btnStable;
        end
    end

    assign loadPos = (state == report_pkg::IDLE) && ((cmdValid && cmdByte == report_pkg::CMD_POSITION)
        || (streamMode && !cmdValid && (accX != 16'sh0 || accY != 16'sh0
        || btnStable != lastButtons)));
    assign loadTest = (state == report_pkg::IDLE) && cmdValid
        && cmdByte == report_pkg::CMD_SELFTEST;

    always_comb begin
        next_accX = accX + 16'(deltaX);
        next_accY = accY + 16'(deltaY);
        if (!moveStrobe) begin
            next_accX = accX;
            next_accY = accY;
        end
        if (loadPos) begin
            // movement in this cycle starts the next report
            next_accX = moveStrobe ? 16'(deltaX) : 16'sh0;
            next_accY = moveStrobe ? 16'(deltaY) : 16'sh0;
        end
        next_streamMode = streamMode;
        if (state == report_pkg::IDLE && cmdValid) begin
            if (cmdByte == report_pkg::CMD_STREAM) begin
                next_streamMode = 1'b1;
            end else if (cmdByte == report_pkg::CMD_PROMPT
                || cmdByte == report_pkg::CMD_POSITION
                || cmdByte == report_pkg::CMD_SELFTEST) begin
                next_streamMode = 1'b0;
            end
        end
        next_lastButtons = loadPos ? btnStable : lastButtons;
    end

    // ------------------------------------------------------------
    // report assembly and sending
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_bytes = bytes;
        next_idx = idx;
        next_lastIdx = lastIdx;
        unique case (state)
            report_pkg::IDLE: begin
                if (loadPos) begin
                    next_bytes[0] = {1'b1, 2'b00, !accX[15], !accY[15], btnStable};
                    // wrap silently above seven bits
                    next_bytes[1] = {1'b0, report_pkg::magnitude(accX)};
                    next_bytes[2] = {1'b0, report_pkg::magnitude(accY)};
                    next_bytes[3] = 8'h00;
                    next_lastIdx = 2'(report_pkg::POS_LEN - 2'h1);
                    next_idx = 2'h0;
                    next_state = report_pkg::SEND;
                end else if (loadTest) begin
                    next_bytes[0] = {report_pkg::SYNC_PATTERN, REVISION};
                    next_bytes[1] = {1'b0, MAKER_ID, DEVICE_ID};
                    next_bytes[2] = {1'b0, testError};
                    next_bytes[3] = {5'h00, switchFault};
                    next_lastIdx = 2'(report_pkg::TEST_LEN - 2'h1);
                    next_idx = 2'h0;
                    next_state = report_pkg::SEND;
                end
            end
            report_pkg::SEND: begin
                if (link.ready) begin
                    next_state = report_pkg::WAIT;
                end
            end
            report_pkg::WAIT: begin
                if (link.ready) begin
                    if (idx == lastIdx) begin
                        next_state = report_pkg::IDLE;
                    end else begin
                        next_idx = idx + 2'h1;
                        next_state = report_pkg::SEND;
                    end
                end
            end
            default: next_state = report_pkg::IDLE;
        endcase
    end

    assign link.valid = (state == report_pkg::SEND);
    assign link.data = bytes[idx];
    assign reportBusy = (state != report_pkg::IDLE);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            accX <= 16'sh0;
            accY <= 16'sh0;
            streamMode <= 1'b0;
            lastButtons <= 3'h0;
            state <= report_pkg::IDLE;
            for (int i = 0; i < 4; i++) begin
                bytes[i] <= 8'h00;
            end
            idx <= 2'h0;
            lastIdx <= 2'h0;
        end else begin
            accX <= next_accX;
            accY <= next_accY;
            streamMode <= next_streamMode;
            lastButtons <= next_lastButtons;
            state <= next_state;
            bytes <= next_bytes;
            idx <= next_idx;
            lastIdx <= next_lastIdx;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    pos_head_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos |=> bytes[0][7:5] == 3'h4 && bytes[0][2:0] == $past(btnStable))
        else $error("position header wrong");
    pos_sign_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos |=> bytes[0][4] == !$past(accX[15]) && bytes[0][3] == !$past(accY[15]))
        else $error("position signs wrong");
    x_mag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos |=> bytes[1] == {1'b0, report_pkg::magnitude($past(accX))})
        else $error("x magnitude wrong");
    y_mag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos |=> bytes[2] == {1'b0, report_pkg::magnitude($past(accY))})
        else $error("y magnitude wrong");
    no_overflow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos |=> bytes[1][7] == 1'b0 && bytes[2][7] == 1'b0)
        else $error("overflow flagged");
    test_sync_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTest |=> bytes[0] == {report_pkg::SYNC_PATTERN, REVISION})
        else $error("self-test sync wrong");
    test_id_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTest |=> bytes[1] == {1'b0, MAKER_ID, DEVICE_ID})
        else $error("identification byte wrong");
    test_rev_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTest |=> bytes[0][4:0] == REVISION && lastIdx == 2'h3)
        else $error("revision or length wrong");
    test_err_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTest |=> bytes[2] == {1'b0, $past(testError)})
        else $error("error code wrong");
    test_sw_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTest |=> bytes[3] == {5'h00, $past(switchFault)})
        else $error("switch byte wrong");
    pos_prompt_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmdValid && state == report_pkg::IDLE && cmdByte == report_pkg::CMD_POSITION
        |=> !streamMode && reportBusy)
        else $error("position request mishandled");
    acc_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadPos && !moveStrobe |=> accX == 16'sh0 && accY == 16'sh0)
        else $error("accumulators not cleared");
    cov_pos: cover property (@(posedge ref_clk) disable iff (!resetn) loadPos);
    cov_test: cover property (@(posedge ref_clk) disable iff (!resetn) loadTest);
    cov_stream: cover property (@(posedge ref_clk) disable iff (!resetn)
        streamMode && loadPos);
    cov_prompt: cover property (@(posedge ref_clk) disable iff (!resetn)
        state == report_pkg::IDLE && cmdValid && cmdByte == report_pkg::CMD_PROMPT);
    cov_wrap: cover property (@(posedge ref_clk) disable iff (!resetn)
        loadPos && (accX > 16'sh007F || accX < -16'sh007F));
endmodule : pointer_report_formatter

/* File: verification/host_serial_rx.sv */
// host-side serial receiver model that decodes report bytes
module host_serial_rx #(
    parameter int BIT_CYCLES = int'(report_pkg::BIT_CYCLES)
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic txd,
    output logic gotByte,
    output logic [7:0] rxByte,
    output logic frameBad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [10:0] sh;
    int cnt;
    int idx;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy = 1'b0;
            cnt = 0;
            idx = 0;
            sh = 11'h000;
            gotByte <= 1'b0;
            rxByte <= 8'h00;
            frameBad <= 1'b0;
        end else begin
            gotByte <= 1'b0;
            if (!busy) begin
                busy = (txd === 1'b0);
                cnt = BIT_CYCLES / 2;
                idx = 0;
            end else if (cnt > 0) begin
                cnt--;
            end else begin
                // mid-bit sample: start, data lsb first, parity, stop
                sh[idx] = txd;
                idx++;
                cnt = BIT_CYCLES - 1;
                if (idx == 11) begin
                    busy = 1'b0;
                    gotByte <= 1'b1;
                    rxByte <= sh[8:1];
                    frameBad <= (sh[0] !== 1'b0) || (^sh[9:1] !== 1'b1) || (sh[10] !== 1'b1);
                end
            end
        end
    end
endmodule : host_serial_rx

/* File: verification/tb_top.sv */
// self-checking bench for the pointer report formatter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] REV = 5'h13;
    localparam logic [2:0] MAKER = 3'h6; // arbitrary value
    localparam logic [3:0] DEV = 4'h5; // arbitrary value
    // short bit time keeps the run small; frame shape is unchanged
    localparam logic [15:0] BAUD_DIV = 16'h0010;
    logic ref_clk, resetn, cmdValid, moveStrobe, txd, streamMode, reportBusy, gotByte, frameBad;
    logic [7:0] cmdByte, rxByte;
    logic signed [1:0] deltaX, deltaY;
    logic [2:0] buttons, switchFault;
    logic [6:0] testError;
    logic [15:0] lfsr;
    int errTotal, totalChecks, sumX, sumY, px, py;

    pointer_report_formatter #(.REVISION(REV), .MAKER_ID(MAKER), .DEVICE_ID(DEV),
        .BIT_CYCLES(BAUD_DIV)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .moveStrobe(moveStrobe), .deltaX(deltaX), .deltaY(deltaY), .buttons(buttons),
        .testError(testError), .switchFault(switchFault), .txd(txd),
        .streamMode(streamMode), .reportBusy(reportBusy));
    host_serial_rx #(.BIT_CYCLES(int'(BAUD_DIV))) rx (.ref_clk(ref_clk), .resetn(resetn),
        .txd(txd), .gotByte(gotByte),
        .rxByte(rxByte), .frameBad(frameBad));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    function automatic logic [7:0] expPos(input int i, input int x, input int y, input logic [2:0] bt);
        int m;
        m = (i == 1) ? x : y;
        m = (m < 0) ? -m : m;
        if (i == 0) return {3'b100, x >= 0, y >= 0, bt};
        return {1'b0, 7'(m % 128)};
    endfunction : expPos

    function automatic logic [7:0] expTest(input int i);
        case (i)
            0: return {report_pkg::SYNC_PATTERN, REV};
            1: return {1'b0, MAKER, DEV};
            2: return {1'b0, testError};
            default: return {5'h00, switchFault};
        endcase
    endfunction : expTest

    task automatic summarize;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic sendCmd(input logic [7:0] c);
        cmdValid = 1'b1;
        cmdByte = c;
        @(negedge ref_clk);
        cmdValid = 1'b0;
        @(negedge ref_clk);
    endtask : sendCmd

    task automatic getByte(input logic [7:0] exp, input string what);
        int i;
        for (i = 0; i < 2000 && gotByte !== 1'b1; i++) @(negedge ref_clk);
        if (i == 2000) begin
            errTotal++;
            summarize();
        end
        chk(what, exp, rxByte);
        chk("frameBad", 8'h00, {7'h00, frameBad});
        @(negedge ref_clk);
    endtask : getByte

    task automatic waitIdle;
        int i;
        for (i = 0; i < 2000 && reportBusy !== 1'b0; i++) @(negedge ref_clk);
        if (i == 2000) begin
            errTotal++;
            summarize();
        end
    endtask : waitIdle

    task automatic moves(input int n, input int fx);
        int dx, dy;
        repeat (n) begin
            lfsr = lfsrNext(lfsr);
            dx = (fx != 0) ? fx : int'(lfsr[3:0] % 3) - 1;
            dy = int'(lfsr[9:4] % 3) - 1;
            moveStrobe = 1'b1;
            deltaX = 2'(dx);
            deltaY = 2'(dy);
            sumX += dx;
            sumY += dy;
            @(negedge ref_clk);
        end
        moveStrobe = 1'b0;
    endtask : moves

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {resetn, cmdValid, moveStrobe, cmdByte, deltaX, deltaY} = '0;
        {buttons, switchFault, testError} = '0;
        lfsr = 16'hEE8C;
        {errTotal, totalChecks, sumX, sumY} = '0;
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        lfsr = lfsrNext(lfsr);
        buttons = lfsr[2:0];
        moves(140, 1);
        moves(30, 0);
        sendCmd(report_pkg::CMD_POSITION);
        chk("reportBusy", 8'h01, {7'h00, reportBusy});
        px = sumX;
        py = sumY;
        {sumX, sumY} = '0;
        moves(2, 1);
        sendCmd(report_pkg::CMD_STREAM);
        chk("streamMode", 8'h00, {7'h00, streamMode});
        getByte(expPos(0, px, py, buttons), "pos byte1");
        getByte(expPos(1, px, py, buttons), "pos byte2");
        getByte(expPos(2, px, py, buttons), "pos byte3");
        waitIdle();
        // movement made during the report shows up alone in stream mode
        sendCmd(report_pkg::CMD_STREAM);
        chk("streamMode", 8'h01, {7'h00, streamMode});
        getByte(expPos(0, sumX, sumY, buttons), "stream byte1");
        getByte(expPos(1, sumX, sumY, buttons), "stream byte2");
        getByte(expPos(2, sumX, sumY, buttons), "stream byte3");
        waitIdle();
        // a button change alone makes a stream report
        {sumX, sumY} = '0;
        buttons = ~buttons;
        getByte(expPos(0, sumX, sumY, buttons), "button byte1");
        getByte(expPos(1, sumX, sumY, buttons), "button byte2");
        getByte(expPos(2, sumX, sumY, buttons), "button byte3");
        waitIdle();
        // prompt mode keeps counting without reporting
        sendCmd(report_pkg::CMD_PROMPT);
        chk("streamMode", 8'h00, {7'h00, streamMode});
        moves(3, 1);
        repeat (4) @(negedge ref_clk);
        chk("reportBusy", 8'h00, {7'h00, reportBusy});
        sendCmd(report_pkg::CMD_POSITION);
        getByte(expPos(0, sumX, sumY, buttons), "prompt byte1");
        getByte(expPos(1, sumX, sumY, buttons), "prompt byte2");
        getByte(expPos(2, sumX, sumY, buttons), "prompt byte3");
        waitIdle();
        lfsr = lfsrNext(lfsr);
        testError = lfsr[0] ? report_pkg::ERR_CHECKSUM : report_pkg::ERR_BUTTON;
        if (lfsr[2:1] == 2'h0) testError = report_pkg::ERR_NONE;
        switchFault = lfsr[6:4];
        sendCmd(report_pkg::CMD_SELFTEST);
        for (int k = 0; k < 4; k++) getByte(expTest(k), "test byte");
        waitIdle();
        chk("reportBusy", 8'h00, {7'h00, reportBusy});
        summarize();
    end
endmodule : tb_top
